// File: inc/mac_rx_defs.svh
// Register offsets, field positions, reset values and frame length limits of the receive control block.
`ifndef MAC_RX_DEFS_SVH
`define MAC_RX_DEFS_SVH
`define OFS_RX_CFG 8'h00
`define OFS_TX_STAT 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0c
`define OFS_RX_AUX 8'h10
`define OFS_RX_CNT 8'h14
`define OFS_RX_STAT 8'h18
`define CFG_PROMISC 15
`define CFG_ALL_MCAST 13
`define CFG_REJ_MII 6
`define CFG_REJ_UND 3
`define CFG_REJ_FRAG 2
`define CFG_RUN 1
`define CFG_EN 0
`define CFG_WMASK 32'h0000a07f
`define CFG_RESET 32'h00000000
`define AUX_THR_HI 10
`define AUX_INV 16
`define AUX_HASH_LO 17
`define AUX_HASH_HI 18
`define AUX_WMASK 32'h000707ff
`define AUX_RESET 32'h00000040
`define TSR_FBE 31
`define TSR_STATE_LO 28
`define TSR_FLAGS_HI 14
`define TSR_RESET 32'h00000000
`define IRQ_STORED 0
`define IRQ_DROPPED 1
`define IRQ_RX_STOP 2
`define IRQ_TX_DONE 3
`define IRQ_FBE 4
`define MIN_FRAME_LEN 11'd64
`define LEN_MAX 11'h7ff
`endif

// File: inc/mac_rx_pkg.sv
// Types shared by the receive control block and its helpers.
package mac_rx_pkg;
	typedef enum logic [2:0] {S_STOP, S_FETCH, S_READY, S_RECV, S_SUSP} rx_mode_t;
	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
	} sync_state_t;
	typedef struct packed {
		rx_mode_t st;
		logic [31:0] cfg;
		logic [31:0] aux;
		logic [31:0] tsr;
		logic [4:0] irq;
		logic [4:0] mask;
		logic [15:0] und_cnt;
		logic [15:0] frag_cnt;
		logic [31:0] rx_stat;
		logic [31:0] prdata;
		logic clk_d;
		logic hi_nib;
		logic [3:0] nib;
		logic [10:0] len;
		logic [47:0] da;
		logic err;
		logic in_frame;
		logic fwd;
		logic [7:0] wdat;
		logic wval;
		logic fend;
		logic keep;
	} rx_state_t;
endpackage : mac_rx_pkg

// File: verilog/mii_sync.sv
// Two-stage synchroniser for the receive pins of the PHY link.
`timescale 1ns/1ns
module mii_sync (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [6:0] pins,
	output logic [6:0] pins_sync
);
	import mac_rx_pkg::*;
	sync_state_t q_r;
	sync_state_t q_nxt;

	// The first stage feeds only the second.
	always_comb begin
		q_nxt.s1 = pins;
		q_nxt.s2 = q_r.s1;
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign pins_sync = q_r.s2;
endmodule : mii_sync

// File: verilog/addr_filter.sv
// Destination address filter: mode selection and hash index.
`timescale 1ns/1ns
module addr_filter (
	input wire logic [47:0] dest_addr,
	input wire logic promiscuous_select,
	input wire logic pass_all_multicast,
	input wire logic inverse_filter_select,
	input wire logic [1:0] hash_mode_select,
	input wire logic perfect_hit,
	input wire logic hash_bit,
	output logic [8:0] hash_index,
	output logic accept
);
	import mac_rx_pkg::*;

	// CRC over the address in wire order, low bit of the first byte first.
	function automatic logic [31:0] addr_crc(input logic [47:0] a);
		logic [31:0] c;
		logic b;
		c = 32'hffffffff;
		for (int i = 0; i < 48; i++) begin
			b = a[40 - 8 * (i / 8) + (i % 8)] ^ c[0];
			c = {1'b0, c[31:1]} ^ (b ? 32'hedb88320 : 32'h00000000);
		end
		return c;
	endfunction : addr_crc

	logic [31:0] crc_full;

	// The nine low CRC bits pick one bit of the external table.
	assign crc_full = addr_crc(dest_addr);
	assign hash_index = crc_full[8:0];

	// Mode selection; promiscuous overrides everything, then all-multicast.
	always_comb begin
		if (promiscuous_select) begin
			accept = 1'b1;
		end else if (pass_all_multicast) begin
			accept = dest_addr[40] | perfect_hit;
		end else if (hash_mode_select[1]) begin
			accept = hash_bit;
		end else if (hash_mode_select[0]) begin
			accept = dest_addr[40] ? hash_bit : perfect_hit;
		end else if (inverse_filter_select) begin
			accept = ~perfect_hit;
		end else begin
			accept = perfect_hit;
		end
	end
endmodule : addr_filter

// File: verilog/mac_rx_ctrl.sv
// Receive control and transmit status of the MAC, with APB registers.
// Operation
// - Config bit 3 rejects undersized frames, bit 2 fragments; both reset low.
// - Event counters count errors whatever the reject bits say.
// - The run bit does nothing while the port enable bit is low.
// - Run with enable starts reception: descriptor fetched before any data moves.
// - Clearing run stops reception, but a frame in progress completes first.
// - The MAC clears the run bit itself when reception stops on error.
// - Suspended for lack of descriptor, reception resumes when a frame arrives.
// - Event counters keep updating while the port is disabled.
// - Rejected frames below the start threshold are discarded, otherwise stored with status.
// - Promiscuous accepts everything; otherwise all-multicast accepts every multicast frame.
// - Otherwise perfect, inverse, hash-plus-perfect or hash-only filtering by selects.
// - Transmit status updates only when a frame ends or aborts; bits 30:28 here follow the transmit state every cycle.
// - Transmit status register reads all zeros after reset.
// - Transmit status bits 30:28 show the transmit process state.
// - Bit 31 flags a fatal bus error and all bus access stops; here only desc_req and mem_wr_valid stop.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "mac_rx_defs.svh"
module mac_rx_ctrl (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mii_rx_clk,
	input wire logic mii_rx_dv,
	input wire logic mii_rx_er,
	input wire logic [3:0] mii_rxd,
	output logic desc_req,
	input wire logic desc_ack,
	input wire logic desc_avail,
	output logic mem_wr_valid,
	output logic [7:0] mem_wr_data,
	output logic mem_frame_end,
	output logic mem_frame_keep,
	input wire logic mem_bus_err,
	output logic [47:0] dest_addr,
	input wire logic perfect_hit,
	input wire logic hash_bit,
	output logic [8:0] hash_index,
	input wire logic [2:0] tx_process_state,
	input wire logic tx_end,
	input wire logic [14:0] tx_flags,
	input wire logic tx_bus_err,
	output logic bus_access_en,
	output logic irq
);
	import mac_rx_pkg::*;
	rx_state_t q_r;
	rx_state_t q_nxt;
	logic [6:0] pin_s;
	logic accept;
	logic run_eff;
	logic rx_edge;
	logic fstart;
	logic fdone;
	logic short_f;
	logic is_und;
	logic is_frag;
	logic rej;
	logic below_thr;
	logic wr;
	logic [7:0] byte_in;
	logic [10:0] len_inc;
	logic bus_err;

	// Link pins pass two flip-flops before use.
	mii_sync u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pins({mii_rx_clk, mii_rx_dv, mii_rx_er, mii_rxd}),
		.pins_sync(pin_s)
	);

	addr_filter u_filt (
		.dest_addr(q_r.da),
		.promiscuous_select(q_r.cfg[`CFG_PROMISC]),
		.pass_all_multicast(q_r.cfg[`CFG_ALL_MCAST]),
		.inverse_filter_select(q_r.aux[`AUX_INV]),
		.hash_mode_select(q_r.aux[`AUX_HASH_HI:`AUX_HASH_LO]),
		.perfect_hit(perfect_hit),
		.hash_bit(hash_bit),
		.hash_index(hash_index),
		.accept(accept)
	);

	// Frame events seen on a rising edge of the sampled link clock.
	assign run_eff = q_r.cfg[`CFG_RUN] & q_r.cfg[`CFG_EN];
	assign rx_edge = pin_s[6] & ~q_r.clk_d;
	assign fstart = rx_edge & pin_s[5] & ~q_r.in_frame;
	assign fdone = rx_edge & ~pin_s[5] & q_r.in_frame;
	assign short_f = q_r.len < `MIN_FRAME_LEN;
	assign is_und = short_f & ~q_r.err;
	assign is_frag = short_f & q_r.err;
	assign rej = (q_r.cfg[`CFG_REJ_UND] & is_und) | (q_r.cfg[`CFG_REJ_FRAG] & is_frag)
		| (q_r.cfg[`CFG_REJ_MII] & q_r.err);
	assign below_thr = q_r.len < q_r.aux[`AUX_THR_HI:0];
	assign wr = psel & penable & pwrite;
	assign byte_in = {pin_s[3:0], q_r.nib};
	assign len_inc = (q_r.len == `LEN_MAX) ? q_r.len : q_r.len + 11'd1;
	assign bus_err = mem_bus_err & q_r.tsr[`TSR_FBE] == 1'b0;

	// Next-state logic for the whole block.
	always_comb begin
		q_nxt = q_r;
		q_nxt.clk_d = pin_s[6];
		q_nxt.wval = 1'b0;
		q_nxt.fend = 1'b0;
		// Register read data is captured in the setup phase.
		if (psel & ~penable) begin
			if (paddr == `OFS_RX_CFG) begin
				q_nxt.prdata = q_r.cfg;
			end else if (paddr == `OFS_TX_STAT) begin
				q_nxt.prdata = q_r.tsr;
			end else if (paddr == `OFS_IRQ_STAT) begin
				q_nxt.prdata = {27'h0, q_r.irq};
			end else if (paddr == `OFS_IRQ_MASK) begin
				q_nxt.prdata = {27'h0, q_r.mask};
			end else if (paddr == `OFS_RX_AUX) begin
				q_nxt.prdata = q_r.aux;
			end else if (paddr == `OFS_RX_CNT) begin
				q_nxt.prdata = {q_r.frag_cnt, q_r.und_cnt};
			end else if (paddr == `OFS_RX_STAT) begin
				q_nxt.prdata = q_r.rx_stat;
			end else begin
				q_nxt.prdata = 32'h00000000;
			end
		end
		// Register writes; hardware events below override them.
		if (wr) begin
			if (paddr == `OFS_RX_CFG) begin
				q_nxt.cfg = pwdata & `CFG_WMASK;
			end else if (paddr == `OFS_TX_STAT) begin
				q_nxt.tsr[`TSR_FBE] = pwdata[`TSR_FBE];
			end else if (paddr == `OFS_IRQ_STAT) begin
				q_nxt.irq = q_r.irq & ~pwdata[4:0];
			end else if (paddr == `OFS_IRQ_MASK) begin
				q_nxt.mask = pwdata[4:0];
			end else if (paddr == `OFS_RX_AUX) begin
				q_nxt.aux = pwdata & `AUX_WMASK;
			end
		end
		// Transmit state mirrors live; flags load only when a frame ends.
		q_nxt.tsr[30:`TSR_STATE_LO] = tx_process_state;
		if (tx_end) begin
			q_nxt.tsr[`TSR_FLAGS_HI:0] = tx_flags;
			q_nxt.irq[`IRQ_TX_DONE] = 1'b1;
		end
		if (tx_bus_err | mem_bus_err) begin
			q_nxt.tsr[`TSR_FBE] = 1'b1;
			q_nxt.irq[`IRQ_FBE] = 1'b1;
		end
		// Nibble assembly and frame tracking run whatever the port enable.
		if (rx_edge & pin_s[5]) begin
			if (fstart) begin
				q_nxt.in_frame = 1'b1;
				q_nxt.len = 11'd0;
				q_nxt.err = pin_s[4];
				q_nxt.fwd = q_r.st == S_READY & run_eff;
				q_nxt.nib = pin_s[3:0];
				q_nxt.hi_nib = 1'b1;
			end else if (~q_r.hi_nib) begin
				q_nxt.nib = pin_s[3:0];
				q_nxt.hi_nib = 1'b1;
				q_nxt.err = q_r.err | pin_s[4];
			end else begin
				q_nxt.hi_nib = 1'b0;
				q_nxt.err = q_r.err | pin_s[4];
				q_nxt.len = len_inc;
				if (q_r.len < 11'd6) begin
					q_nxt.da = {q_r.da[39:0], byte_in};
				end
				q_nxt.wdat = byte_in;
				q_nxt.wval = q_r.fwd & q_r.st == S_RECV & bus_access_en & ~(tx_bus_err | mem_bus_err);
			end
		end
		// Frame end: counters, discard decision and receive status.
		if (fdone) begin
			q_nxt.in_frame = 1'b0;
			if (is_und) begin
				q_nxt.und_cnt = q_r.und_cnt + 16'd1;
			end
			if (is_frag) begin
				q_nxt.frag_cnt = q_r.frag_cnt + 16'd1;
			end
			if (q_r.fwd & q_r.st == S_RECV) begin
				q_nxt.fend = 1'b1;
				q_nxt.keep = accept & ~(rej & below_thr);
				if (accept & ~(rej & below_thr)) begin
					q_nxt.rx_stat = {12'h0, q_r.err, is_frag, is_und, accept, 5'h0, q_r.len};
					q_nxt.irq[`IRQ_STORED] = 1'b1;
				end else begin
					q_nxt.irq[`IRQ_DROPPED] = 1'b1;
				end
			end
		end
		// Reception process.
		case (q_r.st)
			S_STOP: begin
				if (run_eff) begin
					q_nxt.st = S_FETCH;
				end
			end
			S_FETCH: begin
				if (~run_eff) begin
					q_nxt.st = S_STOP;
				end else if (desc_ack) begin
					q_nxt.st = desc_avail ? S_READY : S_SUSP;
				end
			end
			S_READY: begin
				if (~run_eff) begin
					q_nxt.st = S_STOP;
				end else if (fstart) begin
					q_nxt.st = S_RECV;
				end
			end
			S_RECV: begin
				if (fdone | ~q_r.fwd) begin
					q_nxt.st = run_eff ? S_FETCH : S_STOP;
				end
			end
			S_SUSP: begin
				if (~run_eff) begin
					q_nxt.st = S_STOP;
				end else if (fstart) begin
					q_nxt.st = S_FETCH;
				end
			end
			default: begin
				q_nxt.st = S_STOP;
			end
		endcase
		// An error stop clears run; the driver must set it again.
		if (bus_err) begin
			q_nxt.st = S_STOP;
			q_nxt.cfg[`CFG_RUN] = 1'b0;
			q_nxt.irq[`IRQ_RX_STOP] = 1'b1;
		end
	end

	// State register; every field has a constant reset value.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q_r <= '0;
			q_r.st <= S_STOP;
			q_r.cfg <= `CFG_RESET;
			q_r.aux <= `AUX_RESET;
			q_r.tsr <= `TSR_RESET;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Outputs.
	assign bus_access_en = ~q_r.tsr[`TSR_FBE];
	assign desc_req = q_r.st == S_FETCH & bus_access_en;
	assign mem_wr_valid = q_r.wval;
	assign mem_wr_data = q_r.wdat;
	assign mem_frame_end = q_r.fend;
	assign mem_frame_keep = q_r.keep;
	assign dest_addr = q_r.da;
	assign prdata = q_r.prdata;
	assign pready = psel & penable;
	assign pslverr = psel & penable & paddr > `OFS_RX_STAT | psel & penable & paddr[1:0] != 2'b00;
	assign irq = |(q_r.irq & q_r.mask);

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	AST_RUN_GATED: assert property (q_r.st == S_STOP && !q_r.cfg[`CFG_EN] |=> q_r.st == S_STOP)
		else $error("reception started with the port disabled");
	AST_FETCH_FIRST: assert property (q_r.st == S_READY |-> $past(q_r.st) inside {S_FETCH, S_READY})
		else $error("ready state reached without a descriptor fetch");
	AST_FINISH_FRAME: assert property (q_r.st == S_RECV && q_r.fwd && !fdone && !bus_err |=> q_r.st == S_RECV)
		else $error("frame reception cut short");
	AST_ERR_STOP: assert property (bus_err |=> !q_r.cfg[`CFG_RUN] && q_r.st == S_STOP)
		else $error("error did not stop reception and clear run");
	AST_RESUME: assert property (q_r.st == S_SUSP && fstart && run_eff && !bus_err |=> q_r.st == S_FETCH)
		else $error("suspended reception did not resume on a new frame");
	AST_UND_COUNT: assert property (fdone && is_und |=> q_r.und_cnt == $past(q_r.und_cnt) + 16'd1)
		else $error("undersize event not counted");
	AST_COUNT_DISABLED: assert property (fdone && is_frag && !q_r.cfg[`CFG_EN]
		|=> q_r.frag_cnt == $past(q_r.frag_cnt) + 16'd1)
		else $error("fragment not counted while disabled");
	AST_DISCARD: assert property (fdone && q_r.fwd && q_r.st == S_RECV && rej && below_thr
		|=> mem_frame_end && !mem_frame_keep)
		else $error("rejected frame below threshold was kept");
	AST_TSR_HOLD: assert property (!tx_end && !(wr && paddr == `OFS_TX_STAT)
		|=> $stable(q_r.tsr[`TSR_FLAGS_HI:0]))
		else $error("transmit flags changed without a frame end");
	AST_FBE: assert property (tx_bus_err |=> q_r.tsr[`TSR_FBE] && !desc_req && !mem_wr_valid)
		else $error("bus error did not block bus access");
	COV_FRAME_KEPT: cover property (mem_frame_end && mem_frame_keep);
	COV_FRAME_DROPPED: cover property (mem_frame_end && !mem_frame_keep);
	COV_SUSPEND_RESUME: cover property (q_r.st == S_SUSP ##[1:400] q_r.st == S_FETCH);
	COV_ERR_STOP: cover property (bus_err && q_r.st == S_RECV);
endmodule : mac_rx_ctrl

// File: testbench/mii_phy_model.sv
// Behavioural PHY that sends frames on the receive side of the link.
`timescale 1ns/1ns
module mii_phy_model (
	output logic mii_rx_clk,
	output logic mii_rx_dv,
	output logic mii_rx_er,
	output logic [3:0] mii_rxd
);
	// The link clock stands low between frames.
	initial begin
		mii_rx_clk = 1'b0;
		mii_rx_dv = 1'b0;
		mii_rx_er = 1'b0;
		mii_rxd = 4'h5;
	end

	// Sends n counting bytes from b0, low nibble first, then four idle clocks.
	task automatic send(input int n, input logic [7:0] b0, input logic er);
		logic [7:0] b;
		#2; // Keeps every pin change off the sampling edge of the system clock.
		for (int i = 0; i < 2 * n + 4; i++) begin
			b = b0 + 8'(i / 2);
			mii_rx_dv = (i < 2 * n);
			mii_rx_er = er && (i < 2 * n);
			mii_rxd = mii_rx_dv ? (i[0] ? b[7:4] : b[3:0]) : ~mii_rxd; // Idle data is not held.
			#80 mii_rx_clk = 1'b1;
			#80 mii_rx_clk = 1'b0;
		end
	endtask : send
endmodule : mii_phy_model

// File: testbench/testbench.sv
// Self-checking testbench of the receive control block.
`timescale 1ns/1ns
`include "mac_rx_defs.svh"
module testbench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, err, mii_rx_clk, mii_rx_dv, mii_rx_er, desc_req, mem_wr_valid, mem_frame_end;
	logic mem_frame_keep, bus_access_en, irq, keep, early;
	logic [7:0] last_byte;
	logic [3:0] mii_rxd;
	logic [7:0] mem_wr_data;
	logic [47:0] dest_addr;
	logic [8:0] hash_index;
	logic desc_ack = 1'b0;
	logic desc_avail = 1'b0;
	logic avail = 1'b1;
	logic mem_bus_err = 1'b0;
	logic perfect_hit = 1'b0;
	logic hash_bit = 1'b0;
	logic [2:0] tx_process_state = 3'h0;
	logic tx_end = 1'b0;
	logic [14:0] tx_flags = 15'h0000;
	logic tx_bus_err = 1'b0;
	int nb, nend, acks, bad_count, total_checks;

	mii_phy_model phy (.mii_rx_clk(mii_rx_clk), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd));

	mac_rx_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mii_rx_clk(mii_rx_clk),
		.mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd), .desc_req(desc_req), .desc_ack(desc_ack),
		.desc_avail(desc_avail), .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data),
		.mem_frame_end(mem_frame_end), .mem_frame_keep(mem_frame_keep), .mem_bus_err(mem_bus_err),
		.dest_addr(dest_addr), .perfect_hit(perfect_hit), .hash_bit(hash_bit), .hash_index(hash_index),
		.tx_process_state(tx_process_state), .tx_end(tx_end), .tx_flags(tx_flags), .tx_bus_err(tx_bus_err),
		.bus_access_en(bus_access_en), .irq(irq));

	// The clock toggles every half period of 5 ns.
	always #5 ref_clk = ~ref_clk;

	// Answers descriptor requests and tallies stored bytes and frame ends.
	always @(posedge ref_clk) begin
		desc_ack <= (desc_req === 1'b1) && !desc_ack;
		desc_avail <= avail;
		if (desc_ack === 1'b1) acks <= acks + 1;
		if (mem_wr_valid === 1'b1) begin
			nb <= nb + 1;
			last_byte <= mem_wr_data;
			if (acks == 0) early <= 1'b1;
		end
		if (mem_frame_end === 1'b1) begin
			nend <= nend + 1;
			keep <= mem_frame_keep;
		end
	end

	// One APB transfer; read data and error are taken at the pready edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Reference table index: low nine bits of the reflected CRC over the address, first byte first.
	function automatic logic [8:0] crc9(input logic [47:0] a);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int k = 47; k >= 0; k -= 8) begin
			for (int j = 0; j < 8; j++) begin
				c = (c >> 1) ^ ((c[0] ^ a[k - 7 + j]) ? 32'hedb88320 : 32'h00000000);
			end
		end
		return c[8:0];
	endfunction : crc9

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	task automatic clr;
		nb = 0;
		nend = 0;
		acks = 0;
		early = 1'b0;
	endtask : clr

	// Sends one frame under the given filter setup and checks whether it is kept.
	task automatic filt(input logic [31:0] c, input logic [31:0] a, input logic [1:0] h, input logic [7:0] b0,
		input logic exp, input int n);
		apb(1'b1, `OFS_RX_CFG, c);
		apb(1'b1, `OFS_RX_AUX, a);
		hash_bit <= h[1];
		perfect_hit <= h[0];
		clr();
		phy.send(n, b0, 1'b0);
		idle(10);
		chk(nend, 1);
		chk(keep, exp);
	endtask : filt

	task results;
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// Cuts a hang short.
	initial begin
		#800000;
		bad_count++;
		results();
	end

	// Main sequence.
	initial begin
		clr();
		idle(16);
		rst <= 1'b0;
		apb(1'b0, `OFS_RX_CFG, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, `OFS_TX_STAT, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk(err, 1'b1);
		// Run without enable: nothing fetched or stored, counters still count.
		apb(1'b1, `OFS_RX_CFG, 32'h2);
		phy.send(10, 8'h02, 1'b1);
		idle(10);
		chk(nb, 0);
		chk(acks, 0);
		apb(1'b0, `OFS_RX_CNT, 32'h0);
		chk(rdat, 32'h00010000);
		// Run, then clear run in mid-frame: the frame still completes.
		clr();
		apb(1'b1, `OFS_RX_CFG, 32'h8003);
		fork
			phy.send(64, 8'h02, 1'b0);
			begin
				idle(600);
				apb(1'b1, `OFS_RX_CFG, 32'h8001);
			end
		join
		idle(10);
		chk(nb, 64);
		chk(last_byte, 8'h41);
		chk(keep, 1'b1);
		chk(acks, 1);
		chk(early, 1'b0);
		chk(desc_req, 1'b0);
		// Reject bits against the start threshold.
		apb(1'b1, `OFS_RX_CFG, 32'h800b);
		filt(32'h800b, 32'h40, 2'b00, 8'h02, 1'b0, 20);
		filt(32'h800b, 32'h10, 2'b00, 8'h02, 1'b1, 20);
		apb(1'b1, `OFS_RX_CFG, 32'h800f);
		clr();
		phy.send(12, 8'h02, 1'b1);
		idle(10);
		chk(keep, 1'b0);
		apb(1'b0, `OFS_RX_CNT, 32'h0);
		chk(rdat, 32'h00020002);
		// Filter modes.
		filt(32'h3, 32'h40, 2'b00, 8'h02, 1'b0, 64);
		filt(32'h3, 32'h40, 2'b01, 8'h02, 1'b1, 64);
		filt(32'h3, 32'h10040, 2'b01, 8'h02, 1'b0, 64);
		filt(32'h2003, 32'h10040, 2'b00, 8'h01, 1'b1, 64);
		filt(32'h3, 32'h40040, 2'b01, 8'h01, 1'b0, 64);
		filt(32'h3, 32'h40040, 2'b10, 8'h01, 1'b1, 64);
		// Hash for multicast only: a unicast frame needs the perfect match.
		filt(32'h3, 32'h20040, 2'b10, 8'h02, 1'b0, 64);
		chk(dest_addr[47:16], 32'h02030405);
		chk(dest_addr[15:0], 16'h0607);
		chk(hash_index, crc9(48'h020304050607));
		// No descriptor: suspend, then resume on the next frame.
		apb(1'b1, `OFS_RX_CFG, 32'h0);
		avail <= 1'b0;
		apb(1'b1, `OFS_RX_CFG, 32'h8003);
		idle(5);
		avail <= 1'b1;
		clr();
		phy.send(10, 8'h02, 1'b0);
		idle(10);
		chk(acks, 1);
		phy.send(64, 8'h02, 1'b0);
		idle(10);
		chk(nb, 64);
		// Memory bus error in mid-frame stops reception and clears run.
		fork
			phy.send(64, 8'h02, 1'b0);
			begin
				idle(500);
				mem_bus_err <= 1'b1;
				idle(1);
				mem_bus_err <= 1'b0;
			end
		join
		idle(10);
		apb(1'b0, `OFS_RX_CFG, 32'h0);
		chk(rdat[1:0], 2'b01);
		// The memory error also raised the fatal bus error; clear it so descriptors can be fetched.
		apb(1'b1, `OFS_TX_STAT, 32'h0);
		clr();
		apb(1'b1, `OFS_RX_CFG, 32'h8003);
		idle(5);
		chk(acks, 1);
		// Transmit status, its interrupt and the fatal bus error.
		tx_flags <= 15'h1234;
		tx_process_state <= 3'h5;
		apb(1'b1, `OFS_IRQ_MASK, 32'h0);
		apb(1'b0, `OFS_TX_STAT, 32'h0);
		chk(rdat, 32'h50000000);
		tx_end <= 1'b1;
		idle(1);
		tx_end <= 1'b0;
		apb(1'b0, `OFS_TX_STAT, 32'h0);
		chk(rdat[14:0], 15'h1234);
		chk(rdat[30:28], 3'h5);
		chk(irq, 1'b0);
		apb(1'b1, `OFS_IRQ_MASK, 32'h8);
		idle(1);
		chk(irq, 1'b1);
		apb(1'b1, `OFS_IRQ_STAT, 32'h8);
		idle(1);
		chk(irq, 1'b0);
		tx_bus_err <= 1'b1;
		idle(1);
		tx_bus_err <= 1'b0;
		idle(2);
		chk(bus_access_en, 1'b0);
		apb(1'b0, `OFS_TX_STAT, 32'h0);
		chk(rdat[31], 1'b1);
		apb(1'b0, `OFS_IRQ_STAT, 32'h0);
		chk(rdat, 32'h00000017);
		apb(1'b1, `OFS_TX_STAT, 32'h0);
		idle(2);
		chk(bus_access_en, 1'b1);
		results();
	end
endmodule : testbench
